// ---- rtl/nms_sequencer.sv ----
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`default_nettype none

module nms_sequencer (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [nms_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [nms_pkg::HALF_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [nms_pkg::HALF_W-1:0] reg_rdata,
    input wire logic start_rotate,
    input wire logic start_normalize,
    input wire logic start_multiply,
    input wire logic step_pulse,
    output logic sequence_done,
    output logic overflow_fault,
    output logic sequencer_busy,
    output logic normalize_active,
    output logic multiply_active
);

    // rotate a sum-width word left by one place
    function automatic logic [nms_pkg::SUM_W-1:0] rot_sum(input logic [nms_pkg::SUM_W-1:0] v);
        rot_sum = {v[nms_pkg::SUM_W-2:0], v[nms_pkg::SUM_W-1]};
    endfunction

    // rotate a half-width word left by one place
    function automatic logic [nms_pkg::HALF_W-1:0] rot_half(input logic [nms_pkg::HALF_W-1:0] v);
        rot_half = {v[nms_pkg::HALF_W-2:0], v[nms_pkg::HALF_W-1]};
    endfunction

    logic rst_meta_r;
    logic rst_sync_r;
    nms_pkg::nms_state_e state_r;
    nms_pkg::nms_state_e state_nxt;
    logic [nms_pkg::SUM_W-1:0] sum_r;
    logic [nms_pkg::SUM_W-1:0] sum_nxt;
    logic [nms_pkg::HALF_W-1:0] mplr_r;
    logic [nms_pkg::HALF_W-1:0] mplr_nxt;
    logic [nms_pkg::HALF_W-1:0] mcand_r;
    logic [nms_pkg::HALF_W-1:0] mcand_nxt;
    logic [nms_pkg::CNT_W-1:0] count_r;
    logic [nms_pkg::CNT_W-1:0] count_nxt;
    logic norm_act_r;
    logic norm_act_nxt;
    logic mul_act_r;
    logic mul_act_nxt;
    logic seq_ext_r;
    logic seq_ext_nxt;
    logic restore_r;
    logic restore_nxt;
    logic pend_add_r;
    logic pend_add_nxt;
    logic prod_step_r;
    logic prod_step_nxt;
    logic second_probe_r;
    logic second_probe_nxt;
    logic final_add_r;
    logic final_add_nxt;
    logic fault_r;
    logic fault_nxt;
    logic done_r;
    logic done_nxt;
    logic [nms_pkg::HALF_W-1:0] rdata_r;
    logic [nms_pkg::HALF_W-1:0] rdata_nxt;

    // reset release through two flip-flops
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire idle = (state_r == nms_pkg::NMS_IDLE);
    wire any_start = start_rotate | start_normalize | start_multiply;
    wire bus_wr_ok = reg_wr & idle & ~any_start;
    wire fault_clr = reg_wr & (reg_addr == nms_pkg::REG_STATUS) & reg_wdata[nms_pkg::STAT_FAULT];
    wire count_zero = (count_r == nms_pkg::CNT_ZERO);
    wire count_one = (count_r == nms_pkg::CNT_ONE);
    wire count_dec_zero_safe = ~count_zero;
    wire [nms_pkg::CNT_W-1:0] count_dec = count_r - nms_pkg::CNT_ONE;
    wire norm_bits_equal = (sum_r[nms_pkg::SUM_TEST_HI] == sum_r[nms_pkg::SUM_TEST_LO]);
    wire mplr_sign = mplr_r[nms_pkg::MPLR_SIGN];
    wire [nms_pkg::SUM_W-1:0] mcand_ext = {{nms_pkg::HALF_W{mcand_r[nms_pkg::HALF_W-1]}}, mcand_r};
    wire [nms_pkg::SUM_W-1:0] sum_plus_mcand;

    // one's complement sum plus the sign-extended multiplicand
    nms_ones_adder #(
        .WIDTH(nms_pkg::SUM_W)
    ) u_adder (
        .addend_a(sum_r),
        .addend_b(mcand_ext),
        .total(sum_plus_mcand)
    );

    // status word built from the live flags
    wire [nms_pkg::HALF_W-1:0] status_word = {
        26'h0000000,
        final_add_r,
        ~idle,
        second_probe_r,
        prod_step_r,
        pend_add_r,
        restore_r,
        seq_ext_r,
        mul_act_r,
        norm_act_r,
        fault_r
    };

    // read data selection, zero for unmapped indices
    assign rdata_nxt = !reg_rd ? rdata_r :
        (reg_addr == nms_pkg::REG_SUM_LO) ? sum_r[nms_pkg::HALF_W-1:0] :
        (reg_addr == nms_pkg::REG_SUM_HI) ? sum_r[nms_pkg::SUM_W-1:nms_pkg::HALF_W] :
        (reg_addr == nms_pkg::REG_MULTIPLIER) ? mplr_r :
        (reg_addr == nms_pkg::REG_MULTIPLICAND) ? mcand_r :
        (reg_addr == nms_pkg::REG_COUNT) ? {29'h00000000, count_r} :
        (reg_addr == nms_pkg::REG_STATUS) ? status_word :
        36'h000000000;

    // sequencer next-state logic
    always_comb
    begin
        state_nxt = state_r;
        sum_nxt = sum_r;
        mplr_nxt = mplr_r;
        mcand_nxt = mcand_r;
        count_nxt = count_r;
        norm_act_nxt = norm_act_r;
        mul_act_nxt = mul_act_r;
        seq_ext_nxt = seq_ext_r;
        restore_nxt = restore_r;
        pend_add_nxt = pend_add_r;
        prod_step_nxt = prod_step_r;
        second_probe_nxt = second_probe_r;
        final_add_nxt = final_add_r;
        fault_nxt = fault_r;
        done_nxt = 1'b0;
        // software loads operands only while idle
        if (bus_wr_ok)
        begin
            case (reg_addr)
                nms_pkg::REG_SUM_LO: sum_nxt[nms_pkg::HALF_W-1:0] = reg_wdata;
                nms_pkg::REG_SUM_HI: sum_nxt[nms_pkg::SUM_W-1:nms_pkg::HALF_W] = reg_wdata;
                nms_pkg::REG_MULTIPLIER: mplr_nxt = reg_wdata;
                nms_pkg::REG_MULTIPLICAND: mcand_nxt = reg_wdata;
                nms_pkg::REG_COUNT: count_nxt = reg_wdata[nms_pkg::CNT_W-1:0];
                default: count_nxt = count_nxt;
            endcase
        end
        if (fault_clr)
            fault_nxt = 1'b0;
        case (state_r)
            nms_pkg::NMS_IDLE:
            begin
                if (start_rotate)
                begin
                    // zero count finishes without shifting
                    if (count_zero)
                        done_nxt = 1'b1;
                    else
                        state_nxt = nms_pkg::NMS_ROT;
                end
                else if (start_normalize)
                begin
                    count_nxt = nms_pkg::CNT_PRESET_36;
                    norm_act_nxt = 1'b1;
                    state_nxt = nms_pkg::NMS_NORM;
                end
                else if (start_multiply)
                begin
                    if (!norm_bits_equal)
                    begin
                        // danger of overflow: stop, set wins over a clear
                        fault_nxt = 1'b1;
                    end
                    else
                    begin
                        seq_ext_nxt = 1'b1;
                        count_nxt = nms_pkg::CNT_PRESET_36;
                        mul_act_nxt = 1'b1;
                        if (mplr_sign)
                        begin
                            // initial correction subtracts the multiplicand
                            mcand_nxt = ~mcand_r;
                            restore_nxt = 1'b1;
                            pend_add_nxt = 1'b1;
                            state_nxt = nms_pkg::NMS_MADD;
                        end
                        else
                        begin
                            prod_step_nxt = 1'b1;
                            state_nxt = nms_pkg::NMS_MSTEP;
                        end
                    end
                end
            end
            nms_pkg::NMS_ROT:
            begin
                // circular shift of the sum by the loaded count
                if (step_pulse)
                begin
                    sum_nxt = rot_sum(sum_r);
                    count_nxt = count_dec;
                    if (count_one)
                    begin
                        done_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_IDLE;
                    end
                end
            end
            nms_pkg::NMS_NORM:
            begin
                if (step_pulse && norm_act_r)
                begin
                    if (norm_bits_equal)
                    begin
                        sum_nxt = rot_sum(sum_r);
                        if (count_dec_zero_safe)
                            count_nxt = count_dec;
                        else
                            count_nxt = nms_pkg::CNT_PRESET_71;
                        if (count_r == nms_pkg::CNT_NORM_END)
                        begin
                            // 71st shift leaves 37: all zeros or all ones
                            norm_act_nxt = 1'b0;
                            done_nxt = 1'b1;
                            state_nxt = nms_pkg::NMS_IDLE;
                        end
                    end
                    else
                    begin
                        // count now tells shifts needed to restore the word
                        norm_act_nxt = 1'b0;
                        done_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_IDLE;
                    end
                end
            end
            nms_pkg::NMS_MSTEP:
            begin
                if (step_pulse && mul_act_r && prod_step_r)
                begin
                    // rotating both 36 times leaves the multiplier unchanged
                    sum_nxt = rot_sum(sum_r);
                    mplr_nxt = rot_half(mplr_r);
                    count_nxt = count_dec;
                    if (count_one)
                    begin
                        seq_ext_nxt = 1'b0;
                        prod_step_nxt = 1'b0;
                        if (mplr_sign)
                        begin
                            pend_add_nxt = 1'b1;
                            state_nxt = nms_pkg::NMS_MADD;
                        end
                        else
                        begin
                            second_probe_nxt = 1'b1;
                            state_nxt = nms_pkg::NMS_FINAL;
                        end
                    end
                    else if (mplr_sign)
                    begin
                        prod_step_nxt = 1'b0;
                        pend_add_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_MADD;
                    end
                end
            end
            nms_pkg::NMS_MADD:
            begin
                if (step_pulse && pend_add_r)
                begin
                    sum_nxt = sum_plus_mcand;
                    pend_add_nxt = 1'b0;
                    if (restore_r)
                    begin
                        // undo the complement made for the subtraction
                        mcand_nxt = ~mcand_r;
                        restore_nxt = 1'b0;
                    end
                    if (final_add_r)
                    begin
                        final_add_nxt = 1'b0;
                        done_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_IDLE;
                    end
                    else if (!count_zero)
                    begin
                        prod_step_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_MSTEP;
                    end
                    else
                        state_nxt = nms_pkg::NMS_FINAL;
                end
            end
            nms_pkg::NMS_FINAL:
            begin
                if (step_pulse && mul_act_r)
                begin
                    second_probe_nxt = 1'b0;
                    mul_act_nxt = 1'b0;
                    seq_ext_nxt = 1'b0;
                    if (mplr_sign)
                    begin
                        pend_add_nxt = 1'b1;
                        final_add_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_MADD;
                    end
                    else
                    begin
                        done_nxt = 1'b1;
                        state_nxt = nms_pkg::NMS_IDLE;
                    end
                end
            end
            default:
                state_nxt = nms_pkg::NMS_IDLE;
        endcase
    end

    // state and flag registers, cleared by reset
    always_ff @(posedge core_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            state_r <= nms_pkg::NMS_IDLE;
            norm_act_r <= 1'b0;
            mul_act_r <= 1'b0;
            seq_ext_r <= 1'b0;
            restore_r <= 1'b0;
            pend_add_r <= 1'b0;
            prod_step_r <= 1'b0;
            second_probe_r <= 1'b0;
            final_add_r <= 1'b0;
            fault_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            norm_act_r <= norm_act_nxt;
            mul_act_r <= mul_act_nxt;
            seq_ext_r <= seq_ext_nxt;
            restore_r <= restore_nxt;
            pend_add_r <= pend_add_nxt;
            prod_step_r <= prod_step_nxt;
            second_probe_r <= second_probe_nxt;
            final_add_r <= final_add_nxt;
            fault_r <= fault_nxt;
            done_r <= done_nxt;
        end
    end

    // datapath registers and read data
    always_ff @(posedge core_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
        begin
            sum_r <= nms_pkg::SUM_RST;
            mplr_r <= nms_pkg::WORD_RST;
            mcand_r <= nms_pkg::WORD_RST;
            count_r <= nms_pkg::CNT_RST;
            rdata_r <= nms_pkg::WORD_RST;
        end
        else
        begin
            sum_r <= sum_nxt;
            mplr_r <= mplr_nxt;
            mcand_r <= mcand_nxt;
            count_r <= count_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    // busy flag registered alongside the state
    logic busy_r;
    always_ff @(posedge core_clk or negedge rst_sync_r)
    begin
        if (!rst_sync_r)
            busy_r <= 1'b0;
        else
            busy_r <= (state_nxt != nms_pkg::NMS_IDLE);
    end

    // outputs straight from flip-flops
    assign reg_rdata = rdata_r;
    assign sequence_done = done_r;
    assign overflow_fault = fault_r;
    assign sequencer_busy = busy_r;
    assign normalize_active = norm_act_r;
    assign multiply_active = mul_act_r;

endmodule

`default_nettype wire

// ---- pkg/nms_pkg.sv ----
package nms_pkg;

    // datapath widths
    localparam int SUM_W = 72;
    localparam int HALF_W = 36;
    localparam int CNT_W = 7;
    localparam int ADDR_W = 3;

    // bit positions tested by the sequencer
    localparam int SUM_TEST_HI = 35;
    localparam int SUM_TEST_LO = 34;
    localparam int MPLR_SIGN = 35;

    // shift count presets and compare points
    localparam logic [CNT_W-1:0] CNT_ZERO = 7'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] CNT_PRESET_36 = 7'h24;
    localparam logic [CNT_W-1:0] CNT_NORM_END = 7'h26;
    localparam logic [CNT_W-1:0] CNT_PRESET_71 = 7'h47;

    // register indices on the plain register port
    localparam logic [ADDR_W-1:0] REG_SUM_LO = 3'h0;
    localparam logic [ADDR_W-1:0] REG_SUM_HI = 3'h1;
    localparam logic [ADDR_W-1:0] REG_MULTIPLIER = 3'h2;
    localparam logic [ADDR_W-1:0] REG_MULTIPLICAND = 3'h3;
    localparam logic [ADDR_W-1:0] REG_COUNT = 3'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 3'h5;

    // status register field positions
    localparam int STAT_FAULT = 0;
    localparam int STAT_NORM_ACT = 1;
    localparam int STAT_MUL_ACT = 2;
    localparam int STAT_SEQ_EXT = 3;
    localparam int STAT_RESTORE = 4;
    localparam int STAT_PEND_ADD = 5;
    localparam int STAT_PROD_STEP = 6;
    localparam int STAT_SECOND_PROBE = 7;
    localparam int STAT_BUSY = 8;
    localparam int STAT_FINAL_ADD = 9;

    // reset values
    localparam logic [SUM_W-1:0] SUM_RST = 72'h0;
    localparam logic [HALF_W-1:0] WORD_RST = 36'h0;
    localparam logic [CNT_W-1:0] CNT_RST = 7'h00;

    // sequencer states, gray coded in the order listed
    typedef enum logic [2:0] {
        NMS_IDLE = 3'h0,
        NMS_ROT = 3'h1,
        NMS_NORM = 3'h3,
        NMS_MSTEP = 3'h2,
        NMS_MADD = 3'h6,
        NMS_FINAL = 3'h7
    } nms_state_e;

endpackage

// ---- rtl/nms_ones_adder.sv ----
`timescale 1ns/1ps
`default_nettype none

// one's complement adder with end-around carry
module nms_ones_adder #(
    parameter int WIDTH = 72
) (
    input wire logic [WIDTH-1:0] addend_a,
    input wire logic [WIDTH-1:0] addend_b,
    output logic [WIDTH-1:0] total
);

    logic [WIDTH:0] raw_sum;
    logic [WIDTH:0] wrapped;

    // carry out of the top is fed back into the bottom
    assign raw_sum = {1'b0, addend_a} + {1'b0, addend_b};
    assign wrapped = {1'b0, raw_sum[WIDTH-1:0]} + {{WIDTH{1'b0}}, raw_sum[WIDTH]};
    assign total = wrapped[WIDTH-1:0];

endmodule

`default_nettype wire

// ---- rtl/nms_sequencer_unused_placeholder_none.sv ----
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ---- testbench/nms_sequencer_props.sv ----
`timescale 1ns/1ps
`default_nettype none

// watches the sequencer ports for start, step and finish behaviour
module nms_sequencer_props (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic start_rotate,
    input wire logic start_normalize,
    input wire logic start_multiply,
    input wire logic step_pulse,
    input wire logic sequence_done,
    input wire logic overflow_fault,
    input wire logic sequencer_busy,
    input wire logic normalize_active,
    input wire logic multiply_active
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    // accepted starts, after priority and idle qualification, and a step while idle with no start
    sequence s_take_norm;
        start_normalize && !start_rotate && !sequencer_busy;
    endsequence
    sequence s_take_mul;
        start_multiply && !start_rotate && !start_normalize && !sequencer_busy;
    endsequence
    sequence s_idle_step;
        step_pulse && !sequencer_busy && !start_rotate && !start_normalize && !start_multiply;
    endsequence

    a_norm_start_flags: assert property (s_take_norm |=> normalize_active && sequencer_busy)
        else $error("normalize start did not raise active flag");
    a_mul_start_flags: assert property (s_take_mul |=> multiply_active || overflow_fault)
        else $error("multiply start neither ran nor faulted");
    a_fault_stays_idle: assert property ($rose(overflow_fault) |-> !sequencer_busy && !multiply_active && !sequence_done && $past(start_multiply))
        else $error("overflow fault without a refused multiply start");
    a_idle_step_ignored: assert property (s_idle_step |=> !sequencer_busy && !sequence_done)
        else $error("step pulse acted while idle");
    a_norm_waits_step: assert property (normalize_active && !step_pulse |=> normalize_active)
        else $error("normalize ended without a step pulse");
    a_mul_waits_step: assert property (multiply_active && !step_pulse |=> multiply_active)
        else $error("multiply ended without a step pulse");
    a_done_all_clear: assert property (sequence_done |-> !sequencer_busy && !normalize_active && !multiply_active)
        else $error("done while a sequence flag stays set");
    a_done_has_cause: assert property (sequence_done |-> $past(step_pulse) || $past(start_rotate))
        else $error("done with no step or start before it");
    a_one_seq_only: assert property (!(normalize_active && multiply_active))
        else $error("both sequences active");
endmodule

bind nms_sequencer nms_sequencer_props props_u (.core_clk(core_clk), .arst_n(arst_n),
    .start_rotate(start_rotate), .start_normalize(start_normalize), .start_multiply(start_multiply),
    .step_pulse(step_pulse), .sequence_done(sequence_done), .overflow_fault(overflow_fault),
    .sequencer_busy(sequencer_busy), .normalize_active(normalize_active), .multiply_active(multiply_active));

`default_nettype wire

// ---- testbench/nms_cmd_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// command timing unit and step driver: one start, then gated steps until done
module nms_cmd_model (
    input wire logic core_clk,
    input wire logic go,
    input wire logic [1:0] cmd,
    input wire logic slow,
    input wire logic sequence_done,
    input wire logic overflow_fault,
    output logic start_rotate,
    output logic start_normalize,
    output logic start_multiply,
    output logic step_pulse,
    output logic running,
    output int steps
);
    logic gap_r;

    initial
    begin
        {start_rotate, start_normalize, start_multiply, step_pulse, running, gap_r} = 6'h00;
        steps = 0;
    end

    // one start per request; a go during a run starts again at once, running is not checked
    always @(posedge core_clk)
    begin
        start_rotate <= go && cmd == 2'h1;
        start_normalize <= go && cmd == 2'h2;
        start_multiply <= go && cmd == 2'h3;
        gap_r <= slow && !gap_r;
        step_pulse <= running && !gap_r; // steps every cycle, or every other one when slow
        if (go)
        begin
            running <= 1'b1;
            steps <= 0;
        end
        else if (running && (sequence_done || overflow_fault))
            running <= 1'b0;
        else if (running && step_pulse)
            steps <= steps + 1;
    end
endmodule

`default_nettype wire

// ---- testbench/test_nms_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_nms_sequencer;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [nms_pkg::ADDR_W-1:0] reg_addr = 3'h0;
    logic [nms_pkg::HALF_W-1:0] reg_wdata = 36'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [nms_pkg::HALF_W-1:0] reg_rdata;
    logic go = 1'b0;
    logic slow = 1'b0;
    logic [1:0] cmd = 2'h0;
    logic st_rot, st_norm, st_mul, step, done, fault, running;
    int steps;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;

    nms_sequencer dut_u (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .start_rotate(st_rot),
        .start_normalize(st_norm), .start_multiply(st_mul), .step_pulse(step), .sequence_done(done),
        .overflow_fault(fault), .sequencer_busy(), .normalize_active(), .multiply_active());
    nms_cmd_model cmd_u (.core_clk(core_clk), .go(go), .cmd(cmd), .slow(slow), .sequence_done(done),
        .overflow_fault(fault), .start_rotate(st_rot), .start_normalize(st_norm), .start_multiply(st_mul),
        .step_pulse(step), .running(running), .steps(steps));

    // clock and hang guard
    initial
    begin
        forever #2 core_clk = !core_clk;
    end
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // register bus cycles, entered right after a rising edge
    task automatic wr(input logic [2:0] a, input logic [35:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // idle cycle so the next call never re-raises the strobe in this time step
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [2:0] a, output logic [35:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        // read data stand in the cycle after the strobe; take them at its closing edge
        @(posedge core_clk);
        d = reg_rdata;
    endtask
    task automatic put_sum(input logic [71:0] v);
        wr(nms_pkg::REG_SUM_LO, v[35:0]);
        wr(nms_pkg::REG_SUM_HI, v[71:36]);
    endtask
    task automatic get_sum(output logic [71:0] v);
        rd(nms_pkg::REG_SUM_LO, v[35:0]);
        rd(nms_pkg::REG_SUM_HI, v[71:36]);
    endtask
    function automatic logic [71:0] rotl(input logic [71:0] v, input int n);
        return (v << n) | (v >> (72 - n));
    endfunction

    // one command through the partner, waiting for its end under a bound
    task automatic run(input logic [1:0] c, input logic s);
        int n;
        n = 0;
        cmd <= c;
        slow <= s;
        go <= 1'b1;
        @(posedge core_clk);
        go <= 1'b0;
        repeat (2) @(posedge core_clk);
        while (running && n < 500)
        begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 500)
            chk(1'b1, 1'b0);
    endtask

    // reset values and an unmapped index
    task automatic t_reset();
        logic [35:0] d;
        rd(nms_pkg::REG_STATUS, d);
        chk(d, 36'h0);
        rd(nms_pkg::REG_COUNT, d);
        chk(d, 36'h0);
        rd(3'h6, d);
        chk(d, 36'h0);
        // rotate with a zero count finishes at once, no step consumed
        run(2'h1, 1'b0);
        chk(steps, 0);
    endtask

    // pre-rotation then normalize, one case for each class of final count
    task automatic t_norm();
        logic [71:0] a[4] = '{72'h40_0000_0000_0000_0000, 72'h4_0000_0000, 72'h1, 72'h0};
        int k[4] = '{36, 0, 38, 37};
        int n[4] = '{1, 37, 71, 71};
        logic [71:0] s;
        logic [35:0] d;
        for (int i = 0; i < 4; i++)
        begin
            put_sum(a[i]);
            wr(nms_pkg::REG_COUNT, 36'h24);
            run(2'h1, 1'b0);
            get_sum(s);
            chk(s, rotl(a[i], 36));
            run(2'h2, i[0]);
            chk(steps, n[i]);
            rd(nms_pkg::REG_COUNT, d);
            chk(d, k[i]);
            get_sum(s);
            chk(s, rotl(a[i], (72 - k[i]) % 72));
        end
    endtask

    // multiply with both multiplier signs, accumulating into the sum
    task automatic t_mul();
        logic [71:0] a[3] = '{72'd5, 72'h0, 72'h0};
        logic [35:0] q[3] = '{36'd6, ~36'd2, 36'd3};
        logic [35:0] x[3] = '{36'd5, 36'd3, ~36'd4};
        // the sum is rotated 36 times, so a preloaded sum comes back with halves exchanged
        logic [71:0] e[3] = '{72'h5_0000_0001E, ~72'd6, ~72'd12};
        logic [71:0] s;
        logic [35:0] d;
        for (int i = 0; i < 3; i++)
        begin
            put_sum(a[i]);
            wr(nms_pkg::REG_MULTIPLIER, q[i]);
            wr(nms_pkg::REG_MULTIPLICAND, x[i]);
            run(2'h3, i[0]);
            get_sum(s);
            chk(s, e[i]);
            rd(nms_pkg::REG_MULTIPLIER, d);
            chk(d, q[i]);
            rd(nms_pkg::REG_MULTIPLICAND, d);
            chk(d, x[i]);
            rd(nms_pkg::REG_STATUS, d);
            chk(d, 36'h0);
            rd(nms_pkg::REG_COUNT, d);
            chk(d, 36'h0);
        end
    endtask

    // overflow danger refuses the multiply and leaves a sticky fault
    task automatic t_fault();
        logic [71:0] s;
        logic [35:0] d;
        put_sum(72'h8_0000_0000);
        run(2'h3, 1'b0);
        chk(fault, 1'b1);
        get_sum(s);
        chk(s, 72'h8_0000_0000);
        rd(nms_pkg::REG_STATUS, d);
        chk(d, 36'h1);
        wr(nms_pkg::REG_STATUS, 36'h1);
        rd(nms_pkg::REG_STATUS, d);
        chk(d, 36'h0);
    endtask

    // main sequence
    initial
    begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_reset();
        t_norm();
        t_mul();
        t_fault();
        test_done();
    end
endmodule

`default_nettype wire
